// >>> src/frac_div_defs.vh
// register offsets, field positions, masks and reset values of the divider configuration
`ifndef FRAC_DIV_DEFS_VH
`define FRAC_DIV_DEFS_VH

`define ADDR_CLOCK_INPUT_INVERSION    7'h00
`define ADDR_SPREAD_STEP_CONFIG       7'h04
`define ADDR_CHARGE_PUMP_CONFIG       7'h4E
`define ADDR_LOOP_FILTER_CONFIG       7'h4F
`define ADDR_ENABLE_AND_STARTUP_WAIT  7'h73

`define MASK_CLOCK_INPUT_INVERSION    16'h000E
`define MASK_SPREAD_STEP_CONFIG       16'h003F
`define MASK_CHARGE_PUMP_CONFIG       16'h9998
`define MASK_LOOP_FILTER_CONFIG       16'h9990
`define MASK_ENABLE_AND_STARTUP_WAIT  16'hD000

`define RST_CLOCK_INPUT_INVERSION     16'h0000
`define RST_SPREAD_STEP_CONFIG        16'h0027
`define RST_CHARGE_PUMP_CONFIG        16'h0008
`define RST_LOOP_FILTER_CONFIG        16'h0000
`define RST_ENABLE_AND_STARTUP_WAIT   16'h1000

`define BIT_FEEDBACK_INPUT_INVERT     3
`define BIT_SECOND_INPUT_INVERT       2
`define BIT_FIRST_INPUT_INVERT        1
`define FLD_SPREAD_INIT_HI            5
`define FLD_SPREAD_INIT_LO            3
`define FLD_SPREAD_STEP_HI            2
`define FLD_SPREAD_STEP_LO            0
`define BIT_GTS_WAIT                  15
`define BIT_STARTUP_WAIT              14
`define BIT_SYNTH_ENABLE              12

`define NUM_PHASE_TAPS                8

`endif

// >>> src/fractional_divider_config_regs.v
// configuration registers and fractional output counter of the reduced clock-synthesis tile
`include "frac_div_defs.vh"

module fractional_divider_config_regs (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [6:0]  cfg_addr_i,
  input  wire        cfg_en_i,
  input  wire        cfg_we_i,
  input  wire [15:0] cfg_wdata_i,
  output reg  [15:0] cfg_rdata_o,
  output reg         cfg_ready_o,
  input  wire [7:0]  osc_phase_i,
  input  wire        output_counter_enable_i,
  input  wire        fractional_mode_enable_i,
  input  wire [2:0]  phase_tap_select_a_i,
  input  wire [2:0]  phase_tap_select_b_i,
  input  wire [2:0]  phase_tap_step_i,
  output reg         frac_clk_o,
  output reg         aux_clk_o,
  output reg         feedback_input_invert_o,
  output reg         second_input_invert_o,
  output reg         first_input_invert_o,
  output reg  [2:0]  spread_initial_step_count_o,
  output reg  [2:0]  spread_step_count_o,
  output reg  [15:0] charge_pump_config_o,
  output reg  [15:0] loop_filter_config_o,
  output reg  [15:0] enable_and_startup_wait_o
);

  // fractional sequencer states, one-hot
  localparam [2:0] ST_IDLE    = 3'b001;
  localparam [2:0] ST_HIGH    = 3'b010;
  localparam [2:0] ST_LOW     = 3'b100;

  reg  [15:0] clock_input_inversion_q;
  reg  [15:0] spread_step_config_q;
  reg  [7:0]  phase_prev_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  tap_b_q;
  reg  [2:0]  tap_b_d;
  reg  [1:0]  edge_cnt_q;
  reg  [1:0]  edge_cnt_d;
  reg         out_d;
  wire [7:0]  phase_rise;
  wire        rise_a;
  wire        rise_b;
  wire        frac_mode;
  wire        half_ratio;
  wire        cfg_wr;

  // picks the rising-edge flag of one of the eight taps
  function tap_rise;
    input [7:0] rises;
    input [2:0] sel;
    begin
      tap_rise = rises[sel];
    end
  endfunction

  // keeps only the implemented bits of a write
  function [15:0] masked;
    input [15:0] data;
    input [15:0] mask;
    begin
      masked = data & mask;
    end
  endfunction

  assign cfg_wr     = cfg_en_i & cfg_we_i;
  assign phase_rise = osc_phase_i & ~phase_prev_q;
  assign rise_a     = tap_rise(phase_rise, phase_tap_select_a_i);
  assign rise_b     = tap_rise(phase_rise, tap_b_q);
  assign frac_mode  = output_counter_enable_i & fractional_mode_enable_i;
  // a zero step means B stays put: the half-integer case, where A brings the output high
  assign half_ratio = (phase_tap_step_i == 3'h0);

  // register writes; reserved bits never store so they always read zero
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      clock_input_inversion_q   <= `RST_CLOCK_INPUT_INVERSION;
      spread_step_config_q      <= `RST_SPREAD_STEP_CONFIG;
      charge_pump_config_o      <= `RST_CHARGE_PUMP_CONFIG;
      loop_filter_config_o      <= `RST_LOOP_FILTER_CONFIG;
      enable_and_startup_wait_o <= `RST_ENABLE_AND_STARTUP_WAIT;
    end else if (cfg_wr) begin
      case (cfg_addr_i)
        `ADDR_CLOCK_INPUT_INVERSION: begin
          clock_input_inversion_q <= masked(cfg_wdata_i, `MASK_CLOCK_INPUT_INVERSION);
        end
        `ADDR_SPREAD_STEP_CONFIG: begin
          spread_step_config_q <= masked(cfg_wdata_i, `MASK_SPREAD_STEP_CONFIG);
        end
        `ADDR_CHARGE_PUMP_CONFIG: begin
          charge_pump_config_o <= masked(cfg_wdata_i, `MASK_CHARGE_PUMP_CONFIG);
        end
        `ADDR_LOOP_FILTER_CONFIG: begin
          loop_filter_config_o <= masked(cfg_wdata_i, `MASK_LOOP_FILTER_CONFIG);
        end
        `ADDR_ENABLE_AND_STARTUP_WAIT: begin
          enable_and_startup_wait_o <= masked(cfg_wdata_i, `MASK_ENABLE_AND_STARTUP_WAIT);
        end
        default: begin
        end
      endcase
    end
  end

  // read port answers one cycle after the strobe; unmapped offsets read zero
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_ready_o <= 1'b0;
      cfg_rdata_o <= 16'h0000;
    end else begin
      cfg_ready_o <= cfg_en_i;
      if (cfg_en_i && !cfg_we_i) begin
        case (cfg_addr_i)
          `ADDR_CLOCK_INPUT_INVERSION:   cfg_rdata_o <= clock_input_inversion_q;
          `ADDR_SPREAD_STEP_CONFIG:      cfg_rdata_o <= spread_step_config_q;
          `ADDR_CHARGE_PUMP_CONFIG:      cfg_rdata_o <= charge_pump_config_o;
          `ADDR_LOOP_FILTER_CONFIG:      cfg_rdata_o <= loop_filter_config_o;
          `ADDR_ENABLE_AND_STARTUP_WAIT: cfg_rdata_o <= enable_and_startup_wait_o;
          default:                       cfg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // field copies; one cycle behind the register so every output is a flop
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      feedback_input_invert_o     <= 1'b0;
      second_input_invert_o       <= 1'b0;
      first_input_invert_o        <= 1'b0;
      spread_initial_step_count_o <= 3'h4;
      spread_step_count_o         <= 3'h7;
    end else begin
      feedback_input_invert_o     <= clock_input_inversion_q[`BIT_FEEDBACK_INPUT_INVERT];
      second_input_invert_o       <= clock_input_inversion_q[`BIT_SECOND_INPUT_INVERT];
      first_input_invert_o        <= clock_input_inversion_q[`BIT_FIRST_INPUT_INVERT];
      spread_initial_step_count_o <= spread_step_config_q[`FLD_SPREAD_INIT_HI:`FLD_SPREAD_INIT_LO];
      spread_step_count_o         <= spread_step_config_q[`FLD_SPREAD_STEP_HI:`FLD_SPREAD_STEP_LO];
    end
  end

  // fractional sequencer: A (or B) brings the output high, second B edge drops it
  always @* begin
    state_d    = state_q;
    tap_b_d    = tap_b_q;
    edge_cnt_d = edge_cnt_q;
    out_d      = frac_clk_o;
    case (state_q)
      ST_IDLE: begin
        tap_b_d    = phase_tap_select_b_i;
        edge_cnt_d = 2'h0;
        out_d      = 1'b0;
        if (frac_mode && rise_a) begin
          state_d = ST_HIGH;
          out_d   = 1'b1;
        end
      end
      ST_HIGH: begin
        if (rise_b) begin
          if (edge_cnt_q == 2'h1) begin
            state_d    = ST_LOW;
            out_d      = 1'b0;
            edge_cnt_d = 2'h0;
          end else begin
            edge_cnt_d = edge_cnt_q + 2'h1;
          end
        end
      end
      ST_LOW: begin
        if (half_ratio) begin
          // second following A edge restores the output
          if (rise_a) begin
            if (edge_cnt_q == 2'h1) begin
              state_d    = ST_HIGH;
              out_d      = 1'b1;
              edge_cnt_d = 2'h0;
            end else begin
              edge_cnt_d = edge_cnt_q + 2'h1;
            end
          end
        end else if (rise_b) begin
          // adder logic: B hops forward by the step each period
          state_d = ST_HIGH;
          out_d   = 1'b1;
          tap_b_d = tap_b_q + phase_tap_step_i;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!frac_mode) begin
      state_d = ST_IDLE;
      out_d   = 1'b0;
    end
  end

  // sequencer flops and tap edge history; taps are sampled as synchronous inputs
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q      <= ST_IDLE;
      tap_b_q      <= 3'h0;
      edge_cnt_q   <= 2'h0;
      frac_clk_o   <= 1'b0;
      phase_prev_q <= 8'h00;
    end else begin
      state_q      <= state_d;
      tap_b_q      <= tap_b_d;
      edge_cnt_q   <= edge_cnt_d;
      frac_clk_o   <= out_d;
      phase_prev_q <= osc_phase_i;
    end
  end

  // plain counter use: enable without fractional enable divides tap A by two
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aux_clk_o <= 1'b0;
    end else if (output_counter_enable_i && !fractional_mode_enable_i) begin
      if (rise_a) begin
        aux_clk_o <= ~aux_clk_o;
      end
    end else begin
      aux_clk_o <= 1'b0;
    end
  end

endmodule // fractional_divider_config_regs

// >>> verif/cfg_master.sv
// register port master model: one strobe pulse per access
module cfg_master (
  input  wire         sys_clk_i,
  input  wire         cfg_ready_i,
  input  wire  [15:0] cfg_rdata_i,
  output logic        cfg_en_o = 1'b0,
  output logic        cfg_we_o = 1'b0,
  output logic [6:0]  cfg_addr_o = 7'h7F,
  output logic [15:0] cfg_wdata_o = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // address and data stay put until one edge after the edge that samples the answer
  task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d,
                     output logic [15:0] r, output logic ok);
    @(posedge sys_clk_i);
    #1;
    cfg_en_o = 1'b1;
    cfg_we_o = w;
    cfg_addr_o = a;
    cfg_wdata_o = d;
    @(posedge sys_clk_i);
    #1;
    cfg_en_o = 1'b0;
    ok = cfg_ready_i;
    r = cfg_rdata_i;
    @(posedge sys_clk_i);
    #1;
    // released lines must not keep showing the last value
    cfg_addr_o = ~a;
    cfg_wdata_o = ~d;
  endtask
endmodule // cfg_master

// >>> verif/frac_div_properties.sv
// assertion checker for the divider configuration block
module frac_div_properties (
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire [6:0]  cfg_addr_i,
  input wire        cfg_en_i,
  input wire        cfg_we_i,
  input wire [15:0] cfg_wdata_i,
  input wire [15:0] cfg_rdata_o,
  input wire        cfg_ready_o,
  input wire        output_counter_enable_i,
  input wire        fractional_mode_enable_i,
  input wire        frac_clk_o,
  input wire        feedback_input_invert_o,
  input wire        second_input_invert_o,
  input wire        first_input_invert_o,
  input wire [2:0]  spread_initial_step_count_o,
  input wire [2:0]  spread_step_count_o,
  input wire [15:0] charge_pump_config_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // write and read strobes of the register port
  wire wr = cfg_en_i && cfg_we_i;
  wire rd = cfg_en_i && !cfg_we_i;
  property p_rdy; cfg_en_i |=> cfg_ready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer");
  property p_quiet; !cfg_en_i |=> !cfg_ready_o; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without access");
  property p_idle; !(output_counter_enable_i && fractional_mode_enable_i) |=> !frac_clk_o; endproperty
  a_idle: assert property (p_idle) else $error("output while idle");
  property p_inv; wr && cfg_addr_i == 7'h00 |-> ##2
    {feedback_input_invert_o, second_input_invert_o, first_input_invert_o} ==
    $past(cfg_wdata_i[3:1], 2); endproperty
  a_inv: assert property (p_inv) else $error("invert bits wrong");
  property p_spr; wr && cfg_addr_i == 7'h04 |-> ##2
    {spread_initial_step_count_o, spread_step_count_o} == $past(cfg_wdata_i[5:0], 2); endproperty
  a_spr: assert property (p_spr) else $error("spread counts wrong");
  property p_cp; wr && cfg_addr_i == 7'h4E |=>
    charge_pump_config_o == ($past(cfg_wdata_i) & 16'h9998); endproperty
  a_cp: assert property (p_cp) else $error("charge pump wrong");
  property p_rsv; rd && cfg_addr_i == 7'h00 |=> (cfg_rdata_o & 16'hFFF1) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_hole; rd && cfg_addr_i == 7'h10 |=> cfg_rdata_o == 16'h0000; endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  c_spr: cover property (wr && cfg_addr_i == 7'h04);
  c_frac: cover property ($rose(frac_clk_o));
  c_hole: cover property (rd && cfg_addr_i == 7'h10);
endmodule // frac_div_properties

bind fractional_divider_config_regs frac_div_properties u_chk (.*);

// >>> verif/testbench.sv
// self-checking bench for the divider configuration block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0;
  logic        cfg_en_i, cfg_we_i, cfg_ready_o, frac_clk_o, aux_clk_o;
  logic [6:0]  cfg_addr_i;
  logic [15:0] cfg_wdata_i, cfg_rdata_o, charge_pump_config_o, loop_filter_config_o;
  logic [15:0] enable_and_startup_wait_o;
  logic [7:0]  osc_phase_i = 8'h00;
  logic        output_counter_enable_i = 1'b0, fractional_mode_enable_i = 1'b0;
  logic [2:0]  phase_tap_select_a_i = 3'h0, phase_tap_select_b_i = 3'h0, phase_tap_step_i = 3'h0;
  logic        feedback_input_invert_o, second_input_invert_o, first_input_invert_o;
  logic [2:0]  spread_initial_step_count_o, spread_step_count_o;
  int          n_mismatch = 0, n_checks = 0, seed = 95684, vc = 0, h, l;
  int msk [int] = '{7'h00: 16'h000E, 7'h04: 16'h003F, 7'h4E: 16'h9998, 7'h4F: 16'h9990,
                    7'h73: 16'hD000};
  int mdl [int] = '{7'h00: 16'h0000, 7'h04: 16'h0027, 7'h4E: 16'h0008, 7'h4F: 16'h0000,
                    7'h73: 16'h1000};

  fractional_divider_config_regs dut (.*);
  cfg_master m (.sys_clk_i(sys_clk_i), .cfg_ready_i(cfg_ready_o), .cfg_rdata_i(cfg_rdata_o),
    .cfg_en_o(cfg_en_i), .cfg_we_o(cfg_we_i), .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i));

  always #5 sys_clk_i = ~sys_clk_i;
  // eight taps one cycle apart over an eight-cycle oscillator period
  always @(posedge sys_clk_i) begin
    #1;
    vc = vc + 1;
    for (int n = 0; n < 8; n++) osc_phase_i[n] = ((vc + 8 - n) % 8) < 4;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one access; the model keeps only the bits that a place really stores
  task automatic io(input logic w, input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic        ok;
    m.acc(w, a, d, r, ok);
    chk(ok, 1'b1, "ready");
    if (w && msk.exists(a)) mdl[a] = d & msk[a];
    else if (!w) chk(r, mdl.exists(a) ? mdl[a] : 0, "read");
  endtask

  // s picks the watched output: 1 for the plain divided clock, 0 for the fractional one
  task automatic run(input logic s, input logic v, output int n);
    n = 0;
    while ((s ? aux_clk_o : frac_clk_o) === v && n < 60) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
  endtask

  // start tap is loaded while idle, so the fractional enable drops first; runs measured after settling
  // plain divide: each level of the halved tap lasts one whole oscillator period
  task automatic plain(input logic [2:0] a);
    phase_tap_select_a_i = a;
    {output_counter_enable_i, fractional_mode_enable_i} = 2'b10;
    repeat (20) @(posedge sys_clk_i);
    #1;
    chk(frac_clk_o, 1'b0, "frac off");
    run(1'b1, 1'b1, h);
    run(1'b1, 1'b0, h);
    run(1'b1, 1'b1, h);
    run(1'b1, 1'b0, l);
    chk(h, 8, "aux high");
    chk(l, 8, "aux low");
    $display("plain divide done");
  endtask

  task automatic frac(input logic [2:0] b, input logic [2:0] s, input int hi, input int lo);
    phase_tap_select_a_i = 3'h0;
    {output_counter_enable_i, fractional_mode_enable_i} = 2'b10;
    phase_tap_select_b_i = b;
    phase_tap_step_i = s;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk(frac_clk_o, 1'b0, "idle");
    fractional_mode_enable_i = 1'b1;
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk(aux_clk_o, 1'b0, "aux off");
    run(1'b0, 1'b1, h);
    run(1'b0, 1'b0, h);
    run(1'b0, 1'b1, h);
    run(1'b0, 1'b0, l);
    chk(h, hi, "high run");
    chk(l, lo, "low run");
    $display("fractional run done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    foreach (msk[a]) io(1'b0, a[6:0], 16'h0000);
    $display("reset values done");
    repeat (3) begin
      foreach (msk[a]) io(1'b1, a[6:0], 16'($random(seed)));
      foreach (msk[a]) io(1'b0, a[6:0], 16'h0000);
      io(1'b1, 7'h10, 16'hFFFF);
      io(1'b0, 7'h10, 16'h0000);
    end
    $display("read-back done");
    // downward profiles step 011, centred ones 111, all start at 100
    for (int k = 0; k < 4; k++) begin
      io(1'b1, 7'h04, {10'h000, 3'b100, (k < 2) ? 3'b011 : 3'b111});
      chk({spread_initial_step_count_o, spread_step_count_o}, mdl[4], "spread");
      chk({feedback_input_invert_o, second_input_invert_o, first_input_invert_o},
          mdl[0] >> 1, "invert");
      chk({charge_pump_config_o, loop_filter_config_o, enable_and_startup_wait_o},
          {16'(mdl[78]), 16'(mdl[79]), 16'(mdl[115])}, "mirrors");
    end
    $display("spread profiles done");
    repeat (2) plain(3'($random(seed)));
    frac(3'h4, 3'h0, 12, 12);
    frac(3'h2, 3'h2, 10, 8);
    results();
  end
endmodule // testbench
